// ### inc/vrc_pkg.sv
// Purpose: Shared types and constants of the vector rotation angle control
// Assumes: Angle word full scale is one turn; samples are signed fractions
// Notes:   Q15 constants scale the Clarke and three-phase output stages
package vrc_pkg;

	localparam int ANGLE_W      = 12;
	localparam int IN_W         = 16;
	localparam int DAT_W        = 18;
	localparam int FRAC_W       = 15;
	localparam int PHASE_W      = 16;
	localparam int CORDIC_ITER  = 14;
	localparam int CLK_PERIOD_NS = 100;
	localparam int STROBE_MIN_NS = 100;
	localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_MAX_CYC = CORDIC_ITER + 4;

	localparam logic signed [DAT_W-1:0] ONE_THIRD_Q15  = 18'sh02aab;
	localparam logic signed [DAT_W-1:0] INV_SQRT3_Q15  = 18'sh049e7;
	localparam logic signed [DAT_W-1:0] SQRT3_HALF_Q15 = 18'sh06eda;
	localparam logic signed [DAT_W-1:0] CORDIC_GAIN_Q15 = 18'sh04dba;
	localparam logic [PHASE_W-1:0]      HALF_TURN      = 16'h8000;

	typedef enum logic [3:0] {
		CFG_TWO_ORTH  = 4'h1,
		CFG_THREE_3IN = 4'h2,
		CFG_THREE_2IN = 4'h4,
		CFG_UNUSED    = 4'h8
	} vrc_cfg_e;

	typedef struct packed {
		logic signed [IN_W-1:0] cos0;
		logic signed [IN_W-1:0] cos120;
		logic signed [IN_W-1:0] cos240;
		logic signed [IN_W-1:0] sin0;
	} vrc_phase_in_s;

	typedef struct packed {
		logic signed [DAT_W-1:0] d;
		logic signed [DAT_W-1:0] q;
	} vrc_pair_s;

	typedef struct packed {
		logic signed [DAT_W-1:0] ph0;
		logic signed [DAT_W-1:0] ph120;
		logic signed [DAT_W-1:0] ph240;
	} vrc_three_s;

	function automatic logic signed [DAT_W-1:0] mul_q15(
		input logic signed [DAT_W-1:0] a,
		input logic signed [DAT_W-1:0] b
	);
		logic signed [2*DAT_W-1:0] p;
		p = a * b;
		return p[FRAC_W+DAT_W-1:FRAC_W];
	endfunction

endpackage

// ### rtl/vrc_sincos.sv
// Purpose: Iterative sine and cosine generator for one angle word
// Assumes: start is a one-cycle pulse taken only while idle
// Notes:   Angles in the second and third quarter turns are folded by half a turn and negated
`timescale 1ns/10ps
module vrc_sincos
	import vrc_pkg::*;
(
	input  wire logic                      sys_clk,
	input  wire logic                      reset_n,
	input  wire logic                      clk_en,
	input  wire logic                      start,
	input  wire logic [ANGLE_W-1:0]        angle,
	output logic                           done,
	output logic signed [DAT_W-1:0]        sin_q,
	output logic signed [DAT_W-1:0]        cos_q
);

	logic signed [DAT_W-1:0]  x_q, y_q;
	logic signed [PHASE_W-1:0] z_q;
	logic [4:0]               iter_q;
	logic                     run_q, neg_q;
	wire [PHASE_W-1:0]        ang_full = {angle, 4'h0};
	wire                      fold     = ang_full[15] ^ ang_full[14];
	wire [PHASE_W-1:0]        ang_fold = fold ? ang_full + HALF_TURN : ang_full;
	wire signed [DAT_W-1:0]   x_sh     = x_q >>> iter_q;
	wire signed [DAT_W-1:0]   y_sh     = y_q >>> iter_q;
	wire                      dir_neg  = z_q[PHASE_W-1];
	wire                      last     = run_q && (iter_q == 5'(CORDIC_ITER - 1));

	function automatic logic signed [PHASE_W-1:0] atan_step(input logic [4:0] i);
		case (i)
			5'h00: return 16'sh2000;
			5'h01: return 16'sh12e4;
			5'h02: return 16'sh09fb;
			5'h03: return 16'sh0511;
			5'h04: return 16'sh028b;
			5'h05: return 16'sh0146;
			5'h06: return 16'sh00a3;
			5'h07: return 16'sh0051;
			5'h08: return 16'sh0029;
			5'h09: return 16'sh0014;
			5'h0a: return 16'sh000a;
			5'h0b: return 16'sh0005;
			5'h0c: return 16'sh0003;
			default: return 16'sh0001;
		endcase
	endfunction

	wire signed [PHASE_W-1:0] step = atan_step(iter_q);

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			x_q    <= '0;
			y_q    <= '0;
			z_q    <= '0;
			iter_q <= '0;
			run_q  <= 1'b0;
			neg_q  <= 1'b0;
			done   <= 1'b0;
			sin_q  <= '0;
			cos_q  <= CORDIC_GAIN_Q15;
		end else if (clk_en) begin
			done <= last;
			if (start && !run_q) begin
				x_q    <= CORDIC_GAIN_Q15;
				y_q    <= '0;
				z_q    <= signed'(ang_fold);
				iter_q <= '0;
				neg_q  <= fold;
				run_q  <= 1'b1;
			end else if (run_q) begin
				x_q    <= dir_neg ? x_q + y_sh : x_q - y_sh;
				y_q    <= dir_neg ? y_q - x_sh : y_q + x_sh;
				z_q    <= dir_neg ? z_q + step : z_q - step;
				iter_q <= iter_q + 5'h01;
				run_q  <= !last;
			end
			if (last) begin
				// Apart from reset, sine and cosine only change here
				sin_q <= neg_q ? -(dir_neg ? y_q - x_sh : y_q + x_sh)
				               :  (dir_neg ? y_q - x_sh : y_q + x_sh);
				cos_q <= neg_q ? -(dir_neg ? x_q + y_sh : x_q - y_sh)
				               :  (dir_neg ? x_q + y_sh : x_q - y_sh);
			end
		end
	end

	// Done registers with the last step, 14 edges after start, and is sampled high at the 15th
	a_iter_latency: assert property (
		@(posedge sys_clk iff clk_en) disable iff (!reset_n)
		start && !run_q |-> ##15 done) else $error("sine cosine latency wrong");
	a_trig_stable: assert property (
		@(posedge sys_clk iff clk_en) disable iff (!reset_n)
		!last |=> $stable(sin_q) && $stable(cos_q)) else $error("trig changed early");

endmodule

// ### rtl/vrc_angle_ctrl.sv
// Purpose: Angle load, Clarke and Park stages of the vector rotator
// Assumes: Phase samples are synchronous to sys_clk and updated every cycle
// Notes:   Strobes seen while busy are ignored
`timescale 1ns/10ps
module vrc_angle_ctrl
	import vrc_pkg::*;
#(
	parameter logic [DAT_W-1:0] IMBALANCE_LIMIT = 18'h00800
)(
	input  wire logic                 sys_clk,
	input  wire logic                 reset_n,
	input  wire logic                 clk_en,
	input  wire logic [ANGLE_W-1:0]   angle_word_bits,
	input  wire logic                 angle_strobe,
	input  wire logic                 input_config_select_a,
	input  wire logic                 input_config_select_b,
	input  wire vrc_phase_in_s        phase_in,
	output logic                      busy,
	output vrc_pair_s                 rot_pair,
	output vrc_three_s                rot_three,
	output logic                      homopolar_flag
);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CALC = 3'b010,
		ST_LOAD = 3'b100
	} vrc_state_e;

	vrc_state_e               state_q, state_d;
	logic                     strobe_q;
	logic [ANGLE_W-1:0]       angle_q;
	logic                     trig_done;
	logic signed [DAT_W-1:0]  sin_v, cos_v;

	// Strobe edge and load decode
	wire strobe_rise = angle_strobe && !strobe_q;
	wire load_angle  = strobe_rise && (state_q == ST_IDLE);

	// Input configuration decode; an unstrapped select reads high
	wire vrc_cfg_e cfg =
		( input_config_select_a && !input_config_select_b) ? CFG_TWO_ORTH  :
		(!input_config_select_a &&  input_config_select_b) ? CFG_THREE_3IN :
		( input_config_select_a &&  input_config_select_b) ? CFG_THREE_2IN :
		                                                     CFG_UNUSED;

	// Sign-extended phase samples
	wire signed [DAT_W-1:0] in_a = DAT_W'(phase_in.cos0);
	wire signed [DAT_W-1:0] in_b = DAT_W'(phase_in.cos120);
	wire signed [DAT_W-1:0] in_c = DAT_W'(phase_in.cos240);
	wire signed [DAT_W-1:0] in_s = DAT_W'(phase_in.sin0);

	// Clarke stage
	wire signed [DAT_W-1:0] d3 = mul_q15((in_a <<< 1) - in_b - in_c, ONE_THIRD_Q15);
	wire signed [DAT_W-1:0] q3 = mul_q15(in_c - in_b, INV_SQRT3_Q15);
	wire signed [DAT_W-1:0] q2 = -mul_q15(in_a + (in_b <<< 1), INV_SQRT3_Q15);

	wire signed [DAT_W-1:0] d_in =
		(cfg == CFG_THREE_3IN) ? d3 :
		in_a;
	wire signed [DAT_W-1:0] q_in =
		(cfg == CFG_THREE_3IN) ? q3 :
		(cfg == CFG_THREE_2IN) ? q2 :
		in_s;

	// Park rotation
	wire signed [DAT_W-1:0] d_rot = mul_q15(d_in, cos_v) - mul_q15(q_in, sin_v);
	wire signed [DAT_W-1:0] q_rot = mul_q15(d_in, sin_v) + mul_q15(q_in, cos_v);

	// Three-phase output set
	wire signed [DAT_W-1:0] half_d  = d_rot >>> 1;
	wire signed [DAT_W-1:0] q_scale = mul_q15(q_rot, SQRT3_HALF_Q15);
	wire signed [DAT_W-1:0] p120    = -half_d - q_scale;
	wire signed [DAT_W-1:0] p240    = -half_d + q_scale;

	// Homopolar sum and magnitude
	wire signed [DAT_W-1:0] homo_sum = in_a + in_b + in_c;
	wire [DAT_W-1:0]        homo_mag = homo_sum[DAT_W-1] ? DAT_W'(-homo_sum) : homo_sum;
	wire homo_next = (cfg == CFG_THREE_3IN) && (homo_mag > IMBALANCE_LIMIT);

	vrc_sincos u_sincos (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.start   (load_angle),
		.angle   (angle_word_bits),
		.done    (trig_done),
		.sin_q   (sin_v),
		.cos_q   (cos_v)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (load_angle)
					state_d = ST_CALC;
			end
			ST_CALC: begin
				if (trig_done)
					state_d = ST_LOAD;
			end
			ST_LOAD: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	assign busy = (state_q != ST_IDLE);

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_q  <= ST_IDLE;
			strobe_q <= 1'b0;
			angle_q  <= '0;
		end else if (clk_en) begin
			state_q  <= state_d;
			strobe_q <= angle_strobe;
			if (load_angle)
				angle_q <= angle_word_bits;
		end
	end

	// Output registers track the inputs every enabled cycle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rot_pair       <= '0;
			rot_three      <= '0;
			homopolar_flag <= 1'b0;
		end else if (clk_en) begin
			rot_pair.d      <= d_rot;
			rot_pair.q      <= q_rot;
			rot_three.ph0   <= d_rot;
			rot_three.ph120 <= p120;
			rot_three.ph240 <= p240;
			homopolar_flag  <= homo_next;
		end
	end

	a_busy_after_load: assert property (
		@(posedge sys_clk iff clk_en) disable iff (!reset_n)
		load_angle |=> busy && (angle_q == $past(angle_word_bits)))
		else $error("busy or angle not set after load");
	a_busy_bounded: assert property (
		@(posedge sys_clk iff clk_en) disable iff (!reset_n)
		$rose(busy) |-> ##[15:18] !busy)
		else $error("busy length out of range");
	a_busy_held: assert property (
		@(posedge sys_clk iff clk_en) disable iff (!reset_n)
		$rose(busy) |-> busy [*8])
		else $error("busy dropped early");
	a_fall_after_out: assert property (
		@(posedge sys_clk iff clk_en) disable iff (!reset_n)
		$fell(busy) |-> $past(state_q == ST_LOAD) && $past(trig_done, 2))
		else $error("busy fell before outputs updated");
	a_strobe_ignored: assert property (
		@(posedge sys_clk iff clk_en) disable iff (!reset_n)
		busy && strobe_rise |=> $stable(angle_q) && busy)
		else $error("strobe taken while busy");
	a_homo_mode: assert property (
		@(posedge sys_clk iff clk_en) disable iff (!reset_n)
		cfg != CFG_THREE_3IN |=> !homopolar_flag)
		else $error("homopolar flag outside three-phase mode");
	a_homo_sets: assert property (
		@(posedge sys_clk iff clk_en) disable iff (!reset_n)
		(cfg == CFG_THREE_3IN) && (homo_mag > IMBALANCE_LIMIT) |=> homopolar_flag)
		else $error("imbalance not flagged");
	a_two_phase_map: assert property (
		@(posedge sys_clk iff clk_en) disable iff (!reset_n)
		cfg == CFG_TWO_ORTH |-> (d_in == in_a) && (q_in == in_s))
		else $error("two-phase input mapping wrong");
	a_state_onehot: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		$onehot(state_q))
		else $error("state not one-hot");
	a_three_sum: assert property (
		@(posedge sys_clk iff clk_en) disable iff (!reset_n)
		##1 (rot_three.ph120 == -(rot_pair.d >>> 1) - mul_q15(rot_pair.q, SQRT3_HALF_Q15)))
		else $error("three-phase output inconsistent");

endmodule

// ### bench/vrc_host.sv
// Purpose: Host side model that loads angle words into the rotator
// Assumes: Strobe and angle change on rising edges
// Notes:   Angle lines show the inverse word once the strobe is released
`timescale 1ns/10ps
module vrc_host
	import vrc_pkg::*;
(
	input  wire logic          sys_clk,
	input  wire logic          busy,
	output logic [ANGLE_W-1:0] angle_word_bits,
	output logic               angle_strobe
);
	initial begin
		angle_word_bits = '0;
		angle_strobe    = 1'b0;
	end

	// Strobe held for two edges whatever busy does; busy is sampled after the first, then strobe released
	task automatic load(input logic [ANGLE_W-1:0] a, output logic seen);
		@(posedge sys_clk);
		angle_word_bits <= a;
		angle_strobe    <= 1'b1;
		@(posedge sys_clk);
		#1 seen = busy;
		@(posedge sys_clk);
		angle_strobe    <= 1'b0;
		angle_word_bits <= ~a;
	endtask
endmodule

// ### bench/vrc_angle_ctrl_test.sv
// Purpose: Self-checking bench of angle load, busy and rotation outputs
// Assumes: clk_en held high except in the final freeze check; analog results compared within a tolerance
// Notes:   Reference model uses real arithmetic on the rotation equations
`timescale 1ns/10ps
module vrc_angle_ctrl_test
	import vrc_pkg::*;
;
	logic               sys_clk  = 1'b0;
	logic               reset_n  = 1'b0;
	logic               clk_en   = 1'b1;
	logic               sel_a    = 1'b1;
	logic               sel_b    = 1'b0;
	vrc_phase_in_s      phase_in = '0;
	logic [ANGLE_W-1:0] angle_word_bits;
	logic               angle_strobe;
	logic               busy;
	logic               homopolar_flag;
	vrc_pair_s          rot_pair;
	vrc_three_s         rot_three;
	int                 fail_count = 0;
	int                 n_checks   = 0;
	int                 exp_q[$];
	logic [ANGLE_W-1:0] bnd[5] = '{12'h000, 12'h400, 12'h800, 12'hc00, 12'hfff};

	always #50 sys_clk = ~sys_clk;

	vrc_host u_host (
		.sys_clk(sys_clk),
		.busy(busy),
		.angle_word_bits(angle_word_bits),
		.angle_strobe(angle_strobe)
	);

	vrc_angle_ctrl u_dut (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.angle_word_bits(angle_word_bits),
		.angle_strobe(angle_strobe),
		.input_config_select_a(sel_a),
		.input_config_select_b(sel_b),
		.phase_in(phase_in),
		.busy(busy),
		.rot_pair(rot_pair),
		.rot_three(rot_three),
		.homopolar_flag(homopolar_flag)
	);

	task automatic finish_test();
		if (fail_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic signed [DAT_W-1:0] seen, input real e,
		input int tol);
		n_checks++;
		if ($isunknown(seen) || seen - e > tol || e - seen > tol) begin
			$display("ERROR %s expected %0d seen %0d", nm, $rtoi(e), seen);
			fail_count++;
		end
	endtask

	// k: 0 two-phase, 1 three-phase 3 inputs, 2 three-phase 2 inputs, 3 unused code
	task automatic run(input logic [1:0] k, input logic [ANGLE_W-1:0] ang, input bit imb,
		input bit poke);
		real  th, ph, a, b, c, s, d, q, dr, qr;
		logic seen;
		int   n;
		th = $urandom_range(359) * 3.14159265 / 180.0;
		a  = 12000.0 * $cos(th);
		b  = 12000.0 * $cos(th + 2.0943951);
		c  = 12000.0 * $cos(th + 4.1887902) + (imb ? 3000.0 : 0.0);
		s  = 12000.0 * $sin(th);
		@(posedge sys_clk);
		sel_a           <= ~k[0];
		sel_b           <= k[0] ^ k[1];
		phase_in.cos0   <= IN_W'($rtoi(a));
		phase_in.cos120 <= IN_W'($rtoi(b));
		phase_in.cos240 <= IN_W'($rtoi(c));
		phase_in.sin0   <= IN_W'($rtoi(s));
		case (k)
			2'd1: begin
				d = (2.0 * a - b - c) / 3.0;
				q = (c - b) / 1.7320508;
			end
			2'd2: begin
				d = a;
				q = -(a + 2.0 * b) / 1.7320508;
			end
			default: begin
				d = a;
				q = s;
			end
		endcase
		u_host.load(ang, seen);
		chk("busy_rise", seen, 1.0, 0);
		exp_q.push_back(ang);
		n = 1;
		// Second strobe while busy must be ignored
		if (poke) begin
			u_host.load(~ang, seen);
			n += 3;
		end
		for (int i = 0; i < 40; i++) begin
			#1;
			if (busy !== 1'b1) break;
			n++;
			@(posedge sys_clk);
		end
		if (busy === 1'b1) begin
			fail_count++;
			finish_test();
		end
		chk("busy_len", n, CORDIC_ITER + 2, 0);
		ph = exp_q.pop_front() * 6.28318531 / 4096.0;
		dr = d * $cos(ph) - q * $sin(ph);
		qr = d * $sin(ph) + q * $cos(ph);
		chk("rot_d", rot_pair.d, dr, 64);
		chk("rot_q", rot_pair.q, qr, 64);
		chk("ph0", rot_three.ph0, dr, 64);
		chk("ph120", rot_three.ph120, -dr / 2.0 - 0.8660254 * qr, 64);
		chk("ph240", rot_three.ph240, -dr / 2.0 + 0.8660254 * qr, 64);
		chk("homopolar", homopolar_flag, (k == 2'd1 && imb) ? 1.0 : 0.0, 0);
	endtask

	initial begin
		logic signed [DAT_W-1:0] hold;
		void'($urandom(95));
		repeat (5) @(posedge sys_clk);
		#1;
		chk("busy_rst", busy, 0.0, 0);
		chk("rot_rst", rot_pair.d, 0.0, 0);
		chk("hp_rst", homopolar_flag, 0.0, 0);
		@(posedge sys_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			run(2'(i), i < 5 ? bnd[i] : 12'($urandom), i == 13 || i == 14, i == 6);
		end
		// Enable low must freeze the outputs while inputs move
		@(posedge sys_clk);
		clk_en        <= 1'b0;
		phase_in.cos0 <= IN_W'($urandom);
		#1;
		hold = rot_pair.d;
		repeat (3) @(posedge sys_clk);
		#1;
		chk("freeze", rot_pair.d, hold, 0);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		finish_test();
	end
endmodule
